/* src/amc_mode_control.sv */
// Mode control, timing and AHB-Lite registers for the successive-approximation converter
`timescale 1ns/1ns

module amc_mode_control (
   input  wire logic                  core_clk,
   input  wire logic                  arst_n,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic [31:0]                hrdata,
   input  wire logic                  externalTriggerPin,
   input  wire logic                  channelSelectWrite,
   input  wire logic [9:0]            convResult,
   output amc_pkg::amc_conv_type      convCtl,
   output logic                       conversionDoneIrq,
   output logic [9:0]                 conversionResult,
   output logic                       irq
);
   import amc_pkg::*;

   logic [7:0]    modeReg;
   logic          status;
   logic          mask;
   logic          dpActive;
   logic          dpWrite;
   logic          dpLane0;
   logic [29:0]   dpAddr;
   logic          modeWrite;
   logic          statusWrite;
   logic          maskWrite;
   logic          goHold;
   logic          trigPrev;
   logic          edgeHit;
   logic          startOk;
   logic          doneNow;
   logic [7:0]    next_mode;
   amc_state_type state;
   amc_state_type next_state;
   logic [8:0]    count;
   logic [8:0]    next_count;
   logic [2:0]    timeCode;
   logic [1:0]    edgeSel;

   // ---------------------------------------------------------------
   // AHB-Lite slave
   // ---------------------------------------------------------------

   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Address phase capture for the following data phase
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         dpActive <= 1'b0;
         dpWrite  <= 1'b0;
         dpLane0  <= 1'b0;
         dpAddr   <= '0;
      end else if (hready) begin
         dpActive <= hsel & htrans[1];
         dpWrite  <= hwrite;
         dpLane0  <= (haddr[1:0] == 2'b00) | (hsize != 3'b000);
         dpAddr   <= haddr[31:2];
      end
   end

   // Write strobes; only byte lane 0 carries register bits
   assign modeWrite   = dpActive & dpWrite & dpLane0 & (dpAddr == MODE_ADDR[31:2]);
   assign statusWrite = dpActive & dpWrite & dpLane0 & (dpAddr == STATUS_ADDR[31:2]);
   assign maskWrite   = dpActive & dpWrite & dpLane0 & (dpAddr == MASK_ADDR[31:2]);

   // Read mux, unmapped words read as zero
   always_comb begin
      hrdata = '0;
      if (dpActive && !dpWrite) begin
         case (dpAddr)
            MODE_ADDR[31:2]:   hrdata[7:0] = modeReg;
            RESULT_ADDR[31:2]: hrdata[RESULT_LSB +: 10] = conversionResult;
            STATUS_ADDR[31:2]: hrdata[DONE_BIT] = status;
            MASK_ADDR[31:2]:   hrdata[DONE_BIT] = mask;
            default:           hrdata = '0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Mode register
   // ---------------------------------------------------------------

   // Single-bit updates arrive as read-modify-write of the byte
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         modeReg <= MODE_RESET;
      end else if (modeWrite) begin
         modeReg <= hwdata[7:0];
      end
   end

   assign next_mode = modeWrite ? hwdata[7:0] : modeReg;
   assign timeCode  = modeReg[TIME_MSB:TIME_LSB];
   assign edgeSel   = modeReg[EDGE_MSB:EDGE_LSB];

   // ---------------------------------------------------------------
   // Trigger edge detection
   // ---------------------------------------------------------------

   // Pin is taken as already synchronous to the clock
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         trigPrev <= 1'b0;
      end else begin
         trigPrev <= externalTriggerPin;
      end
   end

   // Edge field picks falling (bit 0) and rising (bit 1)
   assign edgeHit = (edgeSel[1] & externalTriggerPin & ~trigPrev)
                  | (edgeSel[0] & ~externalTriggerPin & trigPrev);

   // ---------------------------------------------------------------
   // Conversion sequencer
   // ---------------------------------------------------------------

   // A mode or channel-select write this cycle changes the setup, so nothing starts on it
   assign goHold  = modeWrite | channelSelectWrite;
   assign startOk = modeReg[ENABLE_BIT] & ~goHold
                  & (modeReg[TRIG_BIT] ? edgeHit : 1'b1);
   assign doneNow = (state == CONV) && (count == 9'h000) && !goHold;

   // Next state and counter
   always_comb begin
      next_state = state;
      next_count = (count == 9'h000) ? count : 9'(count - 9'h001);
      case (state)
         IDLE: begin
            if (startOk) begin
               if (modeReg[PDOWN_BIT]) begin
                  next_state = STAB;
                  next_count = 9'((CONV_CYCLES[timeCode] >> 1) - 9'h001);
               end else begin
                  next_state = CONV;
                  next_count = 9'(CONV_CYCLES[timeCode] - 9'h001);
               end
            end
         end
         STAB: begin
            if (goHold) begin
               next_state = IDLE;
            end else if (count == 9'h000) begin
               next_state = CONV;
               next_count = 9'(CONV_CYCLES[timeCode] - 9'h001);
            end
         end
         CONV: begin
            if (goHold) begin
               next_state = IDLE;
            end else if (count == 9'h000) begin
               // Software mode chains straight into the next run
               if (startOk && !modeReg[TRIG_BIT]) begin
                  next_state = modeReg[PDOWN_BIT] ? STAB : CONV;
                  next_count = modeReg[PDOWN_BIT]
                             ? 9'((CONV_CYCLES[timeCode] >> 1) - 9'h001)
                             : 9'(CONV_CYCLES[timeCode] - 9'h001);
               end else begin
                  next_state = IDLE;
               end
            end
         end
         default: begin
            next_state = IDLE;
         end
      endcase
   end

   // Sequencer state
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= IDLE;
         count <= '0;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   // Registered controls toward the analog core
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         convCtl <= '0;
      end else begin
         convCtl.start  <= (next_state == CONV) && ((state != CONV) || doneNow);
         convCtl.abort  <= goHold && (state != IDLE);
         convCtl.busy   <= next_state != IDLE;
         convCtl.compOn <= !next_mode[PDOWN_BIT] || (next_state != IDLE);
      end
   end

   // ---------------------------------------------------------------
   // Result and interrupt
   // ---------------------------------------------------------------

   // Result and done pulse leave on the same edge
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         conversionResult  <= '0;
         conversionDoneIrq <= 1'b0;
      end else begin
         conversionDoneIrq <= doneNow;
         if (doneNow) begin
            conversionResult <= convResult;
         end
      end
   end

   // Sticky done flag; a new completion beats a clearing write
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         status <= 1'b0;
      end else begin
         status <= doneNow | (status & ~(statusWrite & hwdata[DONE_BIT]));
      end
   end

   // Mask register
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         mask <= 1'b0;
      end else if (maskWrite) begin
         mask <= hwdata[DONE_BIT];
      end
   end

   assign irq = status & mask;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------

   mode_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      modeWrite |=> modeReg == $past(hwdata[7:0]))
      else $error("mode register did not take write data");

   stop_idle_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (!modeReg[ENABLE_BIT] && !modeWrite) |=> state == IDLE)
      else $error("converter ran while disabled");

   stab_len_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (state == IDLE && startOk && modeReg[PDOWN_BIT])
      |=> state == STAB && count == 9'((CONV_CYCLES[$past(timeCode)] >> 1) - 9'h001))
      else $error("stabilization count wrong");

   conv_len_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (state == IDLE && startOk && !modeReg[PDOWN_BIT])
      |=> state == CONV && count == 9'(CONV_CYCLES[$past(timeCode)] - 9'h001))
      else $error("conversion count wrong");

   no_edge_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (state == IDLE && modeReg[TRIG_BIT] && edgeSel == 2'b00 && !goHold) |=> state == IDLE)
      else $error("start without a selected edge");

   comp_off_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (next_state == IDLE && next_mode[PDOWN_BIT]) |=> !convCtl.compOn)
      else $error("comparator powered while idle in power-down");

   write_abort_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (goHold && state != IDLE) |=> state == IDLE && convCtl.abort)
      else $error("write did not abort conversion");

   done_load_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      doneNow |=> conversionDoneIrq && conversionResult == $past(convResult) && status)
      else $error("result and interrupt not together");

   sw_repeat_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (doneNow && modeReg[ENABLE_BIT] && !modeReg[TRIG_BIT] && !modeReg[PDOWN_BIT])
      |=> state == CONV && count == 9'(CONV_CYCLES[$past(timeCode)] - 9'h001))
      else $error("software mode did not repeat");

   hw_single_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (doneNow && modeReg[TRIG_BIT]) |=> state == IDLE)
      else $error("hardware mode converted twice");

   stab_conv_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (state == STAB && count == 9'h000 && !goHold)
      |=> state == CONV && count == 9'(CONV_CYCLES[$past(timeCode)] - 9'h001))
      else $error("stabilization did not lead into conversion");

   edge_start_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (state == IDLE && modeReg[ENABLE_BIT] && modeReg[TRIG_BIT] && !goHold
       && ((edgeSel[1] && $rose(externalTriggerPin)) || (edgeSel[0] && $fell(externalTriggerPin))))
      |=> state != IDLE)
      else $error("selected trigger edge did not start a conversion");

   comp_on_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (!next_mode[PDOWN_BIT]) |=> convCtl.compOn)
      else $error("comparator off while power-down is clear");

   done_pulse_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      conversionDoneIrq |=> !conversionDoneIrq)
      else $error("done pulse longer than one cycle");

endmodule // amc_mode_control

/* src/amc_pkg.sv */
// Constants and types for the converter mode control block
package amc_pkg;

   // ---------------------------------------------------------------
   // Register byte addresses
   // ---------------------------------------------------------------
   localparam logic [31:0] MODE_ADDR   = 32'hfffff3c0;
   localparam logic [31:0] RESULT_ADDR = 32'hfffff3c4;
   localparam logic [31:0] STATUS_ADDR = 32'hfffff3c8;
   localparam logic [31:0] MASK_ADDR   = 32'hfffff3cc;

   // ---------------------------------------------------------------
   // Register fields and the mode register reset value
   // ---------------------------------------------------------------
   localparam int          ENABLE_BIT  = 7;
   localparam int          TRIG_BIT    = 6;
   localparam int          TIME_MSB    = 5;
   localparam int          TIME_LSB    = 3;
   localparam int          EDGE_MSB    = 2;
   localparam int          EDGE_LSB    = 1;
   localparam int          PDOWN_BIT   = 0;
   localparam logic [7:0]  MODE_RESET  = 8'h00;
   localparam int          RESULT_LSB  = 6;
   localparam int          DONE_BIT    = 0;

   // ---------------------------------------------------------------
   // Conversion length in clocks for each time code
   // ---------------------------------------------------------------
   localparam logic [8:0] CONV_CYCLES [0:7] = '{9'h120, 9'h0d8, 9'h0a8, 9'h078,
                                                 9'h060, 9'h048, 9'h03c, 9'h030};

   typedef enum logic [1:0] {IDLE, STAB, CONV} amc_state_type;

   // Control toward the analog core
   typedef struct packed {
      logic start;
      logic abort;
      logic busy;
      logic compOn;
   } amc_conv_type;

endpackage

/* tb/amc_core_model.sv */
// Behavioural model of the analog converter core behind the mode control block
`timescale 1ns/1ns

module amc_core_model (
   input  wire logic             core_clk,
   input  wire logic             arst_n,
   input  amc_pkg::amc_conv_type convCtl,
   output logic [9:0]            convResult
);
   import amc_pkg::*;
   logic [9:0] sarValue;
   logic       busyLast;

   // ----------------------------------------
   // New value per started conversion
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sarValue <= 10'h000;
         busyLast <= 1'b0;
      end else begin
         busyLast <= convCtl.busy;
         if (convCtl.start) begin
            sarValue <= sarValue + 10'h15b;
         end
      end
   end

   // Outside a run the value is not held, so a stale sample shows up as wrong
   assign convResult = (convCtl.busy || busyLast) ? sarValue : ~sarValue;
endmodule // amc_core_model

/* tb/amc_mode_control_tb_top.sv */
// Self-checking testbench for the converter mode control block
`timescale 1ns/1ns

module amc_mode_control_tb_top;
   import amc_pkg::*;
   logic core_clk, arst_n, hsel, hwrite, pin, chWr, hready, hresp, irq, doneIrq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [9:0] convResult, result;
   amc_conv_type convCtl;
   int mismatches, samples_checked, n, i, dones;
   typedef struct {logic [7:0] mode; int period;} amc_row_type;
   // Periods: conversion time, plus half of it when power-down is set
   amc_row_type rows [10] = '{'{8'h80,288}, '{8'h88,216}, '{8'h90,168}, '{8'h98,120}, '{8'ha0,96},
                          '{8'ha8,72}, '{8'hb0,60}, '{8'hb8,48}, '{8'h81,432}, '{8'hb9,72}};

   amc_mode_control u_dut (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .externalTriggerPin(pin),
      .channelSelectWrite(chWr), .convResult(convResult), .convCtl(convCtl),
      .conversionDoneIrq(doneIrq), .conversionResult(result), .irq(irq));
   amc_core_model u_core (.core_clk(core_clk), .arst_n(arst_n), .convCtl(convCtl),
      .convResult(convResult));

   // ----------------------------------------
   // Clock, done counter and watchdog
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (doneIrq === 1'b1) dones++;
   initial begin
      #(40 * 40000);
      mismatches++;
      end_sim();
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Single AHB-Lite word transfer, address phase then data phase
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= wr; hsize <= 3'b010;
      do @(posedge core_clk); while (hready !== 1'b1);
      htrans <= 2'b00; hwdata <= d;
      do @(posedge core_clk); while (hready !== 1'b1);
      rd = hrdata;
      check("hresp", 0, hresp);
      hsel <= 1'b0;
   endtask

   // Count edges until the next done pulse, bounded
   task automatic wait_done(input int limit);
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (doneIrq !== 1'b1 && n < limit);
   endtask

   task automatic edge_try(input logic [7:0] mode, input logic lvl, input int expDones);
      xfer(1, MODE_ADDR, {24'h0, mode});
      dones = 0;
      @(posedge core_clk) pin <= lvl;
      // Long enough that a second, unwanted run would also be counted
      repeat (120) @(posedge core_clk);
      check("hw done count", expDones, dones);
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      arst_n = 1'b0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'b010;
      hwdata = 0; pin = 0; chWr = 0; mismatches = 0; samples_checked = 0; dones = 0;
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      xfer(0, MODE_ADDR, 0);
      check("mode reset", 32'h0, rd);
      // Every code, software start; mode kept in the 5..100 us band is software's job
      for (i = 0; i < 10; i++) begin
         xfer(1, MODE_ADDR, {24'h0, rows[i].mode});
         wait_done(1000);
         wait_done(1000);
         check("period", rows[i].period, n);
      end
      @(negedge core_clk);
      check("result out", u_core.sarValue, result);
      xfer(0, RESULT_ADDR, 0);
      check("result reg", {16'h0, u_core.sarValue, 6'h0}, rd);
      // Abort by channel write restarts the full count
      xfer(1, MODE_ADDR, 32'h80);
      wait_done(1000);
      repeat (100) @(posedge core_clk);
      chWr <= 1'b1;
      @(posedge core_clk) chWr <= 1'b0;
      wait_done(1000);
      check("restart long", 1, n >= 288 && n <= 292);
      // Stopped, readback and comparator power
      xfer(1, MODE_ADDR, 32'h5a);
      xfer(0, MODE_ADDR, 0);
      check("mode rb", 32'h5a, rd);
      check("comp on", 1, convCtl.compOn);
      // Software start with enable clear, so only the enable bit keeps it still
      xfer(1, MODE_ADDR, 32'h3b);
      repeat (2) @(posedge core_clk);
      check("comp off", 0, convCtl.compOn);
      dones = 0;
      repeat (400) @(posedge core_clk);
      check("stopped", 0, dones);
      // Hardware start per edge select
      edge_try(8'hfc, 1'b1, 1);
      edge_try(8'hfc, 1'b0, 0);
      edge_try(8'hf8, 1'b1, 0);
      edge_try(8'hfa, 1'b0, 1);
      edge_try(8'hfe, 1'b1, 1);
      // Interrupt mask and write-one clear
      xfer(1, MODE_ADDR, 0);
      xfer(1, MASK_ADDR, 1);
      // Writes land on the data phase edge, so look half a cycle later
      @(negedge core_clk);
      check("irq on", 1, irq);
      xfer(1, STATUS_ADDR, 1);
      @(negedge core_clk);
      check("irq clr", 0, irq);
      xfer(0, 32'hfffff3d0, 0);
      check("unmapped", 0, rd);
      // Reset in mid-run clears mode, status and mask
      xfer(1, MODE_ADDR, 32'h80);
      wait_done(1000);
      arst_n <= 1'b0;
      @(posedge core_clk) arst_n <= 1'b1;
      xfer(0, MODE_ADDR, 0);
      check("mode reset run", 32'h0, rd);
      check("busy reset", 0, convCtl.busy);
      check("irq reset", 0, irq);
      end_sim();
   end
endmodule // amc_mode_control_tb_top
